// ### inc/bfs_cfg.svh
// constants for the buck fault and mode sequencer
`ifndef BFS_CFG_SVH
`define BFS_CFG_SVH
// ****************************************************
// hiccup, clamp and standby thresholds, in switching cycles
// ****************************************************
`define BFS_HICCUP_LIMIT 10'h200
`define BFS_CLAMP_LIMIT 10'h020
`define BFS_CLEAN_LIMIT 3'h4
`define BFS_MISS_LIMIT 5'h10
// ****************************************************
// dead-time delay and mode-clock detection
// ****************************************************
`define BFS_DEAD_NS 20
`define BFS_CLK_NS 10
`define BFS_DEAD_CYC (((`BFS_DEAD_NS + `BFS_CLK_NS - 1) / `BFS_CLK_NS))
`define BFS_TOGGLE_WIN 8'hff
`endif

// ### inc/bfs_pkg.sv
// types for the buck fault and mode sequencer
package bfs_pkg;
    // hiccup sequence states
    typedef enum logic [1:0] {
        BFS_RUN,
        BFS_WAIT_RESTART,
        BFS_SOFTSTART
    } bfs_hiccup_e;
    // gate drive sequencer states
    typedef enum logic [2:0] {
        BFS_OFF,
        BFS_HS_WAIT,
        BFS_HS_ON,
        BFS_LS_WAIT,
        BFS_LS_ON
    } bfs_gate_e;
    typedef logic [9:0] bfs_count_t;
endpackage

// ### design/bfs_mode_decode.sv
// decodes the conduction mode select input, high or toggling means continuous
`timescale 1ns/10ps
`include "bfs_cfg.svh"
module bfs_mode_decode (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // mode pin level
    input wire logic conduction_mode_select,
    // decoded mode
    output logic forced_continuous_mode
);
    import bfs_pkg::*;
    logic last_ff; // previous pin level
    logic [7:0] quiet_ff; // cycles since last edge
    // ****************************************************
    // edge watch: toggling counts as continuous
    // ****************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            last_ff <= 1'b0;
            quiet_ff <= `BFS_TOGGLE_WIN;
        end else begin
            last_ff <= conduction_mode_select;
            if (last_ff != conduction_mode_select) begin
                quiet_ff <= 8'h00;
            end else if (quiet_ff != `BFS_TOGGLE_WIN) begin
                quiet_ff <= quiet_ff + 8'h01;
            end
        end
    end
    // high level or recent edge selects continuous
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            forced_continuous_mode <= 1'b1;
        end else begin
            forced_continuous_mode <= conduction_mode_select | (quiet_ff != `BFS_TOGGLE_WIN);
        end
    end
endmodule

// ### design/bfs_gate_seq.sv
// adaptive dead-time sequencer for the two gate drives
`timescale 1ns/10ps
`include "bfs_cfg.svh"
module bfs_gate_seq (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // demands
    input wire logic hs_demand,
    input wire logic ls_demand,
    // gate comparators: gate below 2.5 V
    input wire logic hs_gate_low,
    input wire logic ls_gate_low,
    // drives
    output logic high_side_gate_drive,
    output logic low_side_gate_drive
);
    import bfs_pkg::*;
    bfs_gate_e state_ff; // sequencer state
    logic [3:0] dly_ff; // fixed delay counter
    // ****************************************************
    // break-before-make sequencing
    // ****************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= BFS_OFF;
            dly_ff <= 4'h0;
        end else begin
            unique case (state_ff)
                BFS_OFF: begin
                    dly_ff <= 4'h0;
                    if (hs_demand) state_ff <= BFS_HS_WAIT;
                    else if (ls_demand) state_ff <= BFS_LS_WAIT;
                end
                // wait for low gate low, then delay
                BFS_HS_WAIT: begin
                    if (!hs_demand) state_ff <= BFS_OFF;
                    else if (ls_gate_low) begin
                        if (dly_ff == 4'(`BFS_DEAD_CYC - 1)) state_ff <= BFS_HS_ON;
                        else dly_ff <= dly_ff + 4'h1;
                    end else dly_ff <= 4'h0;
                end
                BFS_HS_ON: begin
                    if (!hs_demand) state_ff <= BFS_OFF;
                end
                // high gate must fall first
                BFS_LS_WAIT: begin
                    if (!ls_demand || hs_demand) state_ff <= BFS_OFF;
                    else if (hs_gate_low) begin
                        if (dly_ff == 4'(`BFS_DEAD_CYC - 1)) state_ff <= BFS_LS_ON;
                        else dly_ff <= dly_ff + 4'h1;
                    end else dly_ff <= 4'h0;
                end
                BFS_LS_ON: begin
                    if (!ls_demand || hs_demand) state_ff <= BFS_OFF;
                end
                default: state_ff <= BFS_OFF;
            endcase
        end
    end
    // drives decoded from one state, never both
    assign high_side_gate_drive = (state_ff == BFS_HS_ON);
    assign low_side_gate_drive = (state_ff == BFS_LS_ON);
    property p_excl;
        @(posedge clk) disable iff (sys_rst)
        !(high_side_gate_drive && low_side_gate_drive);
    endproperty
    a_excl: assert property (p_excl) else $error("both gate drives on");
endmodule

// ### design/bfs_sequencer.sv
// fault, mode and standby sequencer of a synchronous buck controller
// ****************************************************
// ****************************************************
`timescale 1ns/10ps
`include "bfs_cfg.svh"
module bfs_sequencer (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // switching cycle timing
    input wire logic cycle_start,
    input wire logic pwm_demand,
    // comparators
    input wire logic current_limit,
    input wire logic reverse_current,
    input wire logic restart_at_threshold,
    input wire logic softstart_pin_low,
    input wire logic hs_gate_low,
    input wire logic ls_gate_low,
    // mode pin
    input wire logic conduction_mode_select,
    // gate drives
    output logic high_side_gate_drive,
    output logic low_side_gate_drive,
    // pin controls
    output logic restart_timer_pin_pull_low,
    output logic restart_charge_enable,
    output logic softstart_pull_low,
    output logic softstart_clamp_enable,
    output logic comp_pull_low,
    output logic standby,
    output logic forced_continuous_mode
);
    import bfs_pkg::*;
    bfs_hiccup_e hic_ff; // hiccup state
    bfs_count_t lim_cnt_ff; // limited-cycle counter
    logic [2:0] clean_ff; // clean cycles in a row
    logic [4:0] miss_ff; // cycles without demand
    logic lim_seen_ff; // limit hit this cycle
    logic dem_seen_ff; // demand seen this cycle
    logic hs_term_ff; // high side ended this cycle
    logic rev_ff; // reverse current this cycle
    logic clamp_hold_ff; // emulation clamp latch
    logic hs_dem, ls_dem; // demand to gate sequencer
    logic hs_drv, ls_drv; // sequencer outputs
    logic fault_off; // own fault shutdown
    logic lim_now, dem_now; // this cycle incl. current input
    // ****************************************************
    // mode decode and gate sequencer
    // ****************************************************
    bfs_mode_decode u_mode (
        .clk(clk),
        .sys_rst(sys_rst),
        .conduction_mode_select(conduction_mode_select),
        .forced_continuous_mode(forced_continuous_mode)
    );
    bfs_gate_seq u_gate (
        .clk(clk),
        .sys_rst(sys_rst),
        .hs_demand(hs_dem),
        .ls_demand(ls_dem),
        .hs_gate_low(hs_gate_low),
        .ls_gate_low(ls_gate_low),
        .high_side_gate_drive(hs_drv),
        .low_side_gate_drive(ls_drv)
    );
    assign lim_now = lim_seen_ff | current_limit;
    assign dem_now = dem_seen_ff | pwm_demand;
    assign fault_off = (hic_ff != BFS_RUN);
    // ****************************************************
    // per-cycle event capture
    // ****************************************************
    always_ff @(posedge clk) begin
        if (sys_rst || cycle_start) begin
            lim_seen_ff <= 1'b0;
            dem_seen_ff <= 1'b0;
            hs_term_ff <= 1'b0;
            rev_ff <= 1'b0;
        end else begin
            if (current_limit) lim_seen_ff <= 1'b1;
            if (pwm_demand) dem_seen_ff <= 1'b1;
            if (current_limit || (dem_seen_ff && !pwm_demand)) hs_term_ff <= 1'b1;
            if (reverse_current && !forced_continuous_mode) rev_ff <= 1'b1;
        end
    end
    // high side while demanded and not limited; low side rest of the cycle, in emulation only until reverse current
    always_comb begin
        hs_dem = pwm_demand && !current_limit && !hs_term_ff && !fault_off && !standby;
        ls_dem = 1'b0;
        if (fault_off) begin
            ls_dem = 1'b0;
        end else if (softstart_pin_low && forced_continuous_mode) begin
            ls_dem = 1'b1;
        end else if (!hs_dem && dem_now && !standby) begin
            ls_dem = !rev_ff && !(reverse_current && !forced_continuous_mode);
        end
    end
    // ****************************************************
    // hiccup counter on cycle boundaries
    // ****************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lim_cnt_ff <= 10'h000;
            clean_ff <= 3'h0;
        end else if (cycle_start) begin
            if (lim_now) begin
                clean_ff <= 3'h0;
                if (lim_cnt_ff != `BFS_HICCUP_LIMIT) lim_cnt_ff <= lim_cnt_ff + 10'h001;
            end else if (clean_ff == `BFS_CLEAN_LIMIT - 3'h1) begin
                clean_ff <= 3'h0;
                lim_cnt_ff <= 10'h000;
            end else begin
                clean_ff <= clean_ff + 3'h1;
            end
        end else if (hic_ff == BFS_WAIT_RESTART) begin
            lim_cnt_ff <= 10'h000;
        end
    end
    // ****************************************************
    // hiccup sequence
    // ****************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hic_ff <= BFS_RUN;
        end else begin
            unique case (hic_ff)
                BFS_RUN: if (lim_cnt_ff == `BFS_HICCUP_LIMIT) hic_ff <= BFS_WAIT_RESTART;
                BFS_WAIT_RESTART: if (restart_at_threshold) hic_ff <= BFS_SOFTSTART;
                BFS_SOFTSTART: hic_ff <= BFS_RUN;
                // unused code falls back to normal run
                default: hic_ff <= BFS_RUN;
            endcase
        end
    end
    // emulation clamp latch, held until counter clears
    always_ff @(posedge clk) begin
        if (sys_rst || lim_cnt_ff == 10'h000) begin
            clamp_hold_ff <= 1'b0;
        end else if (lim_cnt_ff >= `BFS_CLAMP_LIMIT) begin
            clamp_hold_ff <= 1'b1;
        end
    end
    // ****************************************************
    // standby on missing cycles
    // ****************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            miss_ff <= 5'h00;
            standby <= 1'b0;
        end else if (pwm_demand || forced_continuous_mode) begin
            miss_ff <= 5'h00;
            standby <= 1'b0;
        end else if (cycle_start && !dem_seen_ff) begin
            if (miss_ff == `BFS_MISS_LIMIT - 5'h01) standby <= 1'b1;
            else miss_ff <= miss_ff + 5'h01;
        end else if (cycle_start) begin
            miss_ff <= 5'h00;
        end
    end
    // ****************************************************
    // registered pin controls
    // ****************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            restart_timer_pin_pull_low <= 1'b1;
            restart_charge_enable <= 1'b0;
            softstart_pull_low <= 1'b0;
            comp_pull_low <= 1'b0;
            softstart_clamp_enable <= 1'b1;
            high_side_gate_drive <= 1'b0;
            low_side_gate_drive <= 1'b0;
        end else begin
            restart_timer_pin_pull_low <= (hic_ff != BFS_WAIT_RESTART);
            restart_charge_enable <= (hic_ff == BFS_WAIT_RESTART);
            softstart_pull_low <= (hic_ff == BFS_WAIT_RESTART);
            comp_pull_low <= (hic_ff == BFS_WAIT_RESTART) || softstart_pin_low;
            softstart_clamp_enable <= forced_continuous_mode || clamp_hold_ff;
            high_side_gate_drive <= hs_drv && !fault_off;
            low_side_gate_drive <= ls_drv && !fault_off && !hs_drv;
        end
    end
    // ****************************************************
    // assertions
    // ****************************************************
    sequence s_wait;
        hic_ff == BFS_WAIT_RESTART;
    endsequence
    property p_shutdown;
        @(posedge clk) disable iff (sys_rst)
        s_wait ##1 s_wait |-> softstart_pull_low && !high_side_gate_drive && restart_charge_enable;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("hiccup outputs wrong");
    property p_restart_low;
        @(posedge clk) disable iff (sys_rst)
        $past(hic_ff) == BFS_RUN && hic_ff == BFS_RUN |-> restart_timer_pin_pull_low;
    endproperty
    a_restart_low: assert property (p_restart_low) else $error("restart not held low");
    property p_resume;
        @(posedge clk) disable iff (sys_rst)
        s_wait and restart_at_threshold |-> ##2 !softstart_pull_low && restart_timer_pin_pull_low;
    endproperty
    a_resume: assert property (p_resume) else $error("no restart");
    property p_fcm_clamp;
        @(posedge clk) disable iff (sys_rst)
        forced_continuous_mode |=> softstart_clamp_enable;
    endproperty
    a_fcm_clamp: assert property (p_fcm_clamp) else $error("clamp off in continuous");
    property p_no_standby;
        @(posedge clk) disable iff (sys_rst)
        forced_continuous_mode |=> !standby;
    endproperty
    a_no_standby: assert property (p_no_standby) else $error("standby in continuous");
    property p_wake;
        @(posedge clk) disable iff (sys_rst)
        pwm_demand |=> !standby && miss_ff == 5'h00;
    endproperty
    a_wake: assert property (p_wake) else $error("standby kept with demand");
    property p_fault_ls;
        @(posedge clk) disable iff (sys_rst)
        softstart_pull_low |-> !low_side_gate_drive;
    endproperty
    a_fault_ls: assert property (p_fault_ls) else $error("low side on in fault");
    property p_excl2;
        @(posedge clk) disable iff (sys_rst)
        !(high_side_gate_drive && low_side_gate_drive);
    endproperty
    a_excl2: assert property (p_excl2) else $error("both drives on");
    property p_clean;
        @(posedge clk) disable iff (sys_rst)
        cycle_start && !lim_now && clean_ff == 3'h3 |=> lim_cnt_ff == 10'h000;
    endproperty
    a_clean: assert property (p_clean) else $error("counter not cleared");
endmodule

// ### testbench/bfs_power_stage.sv
// behavioural power stage: gate comparators, restart and soft-start capacitors
`timescale 1ns/10ps
module bfs_power_stage #(
    parameter int FALL = 2,
    parameter int RCHG = 200,
    parameter int SSCHG = 40
) (
    // clock
    input wire logic clk,
    // device drives
    input wire logic high_side_gate_drive,
    input wire logic low_side_gate_drive,
    input wire logic restart_timer_pin_pull_low,
    input wire logic restart_charge_enable,
    input wire logic softstart_pull_low,
    // outside pull on soft-start, only where a scenario orders it
    input wire logic ext_ss_pull,
    // comparators
    output logic hs_gate_low,
    output logic ls_gate_low,
    output logic restart_at_threshold,
    output logic softstart_pin_low
);
    int hs_cnt = FALL; // clocks since high gate released
    int ls_cnt = FALL; // clocks since low gate released
    int res_lvl = 0; // restart capacitor charge
    int ss_lvl = SSCHG; // soft-start capacitor, charged at power-up
    // gates discharge slowly, so the comparator trips late
    always @(posedge clk) begin
        hs_cnt <= high_side_gate_drive ? 0 : (hs_cnt < FALL ? hs_cnt + 1 : hs_cnt);
        ls_cnt <= low_side_gate_drive ? 0 : (ls_cnt < FALL ? ls_cnt + 1 : ls_cnt);
    end
    assign hs_gate_low = hs_cnt >= FALL;
    assign ls_gate_low = ls_cnt >= FALL;
    // capacitors: discharged while pulled, charged by the current source
    always @(posedge clk) begin
        if (restart_timer_pin_pull_low) res_lvl <= 0;
        else if (restart_charge_enable && res_lvl < RCHG) res_lvl <= res_lvl + 1;
        if (softstart_pull_low || ext_ss_pull) ss_lvl <= 0;
        else if (ss_lvl < SSCHG) ss_lvl <= ss_lvl + 1;
    end
    assign restart_at_threshold = res_lvl >= RCHG;
    assign softstart_pin_low = ss_lvl < SSCHG;
endmodule

// ### testbench/buck_fault_mode_sequencer_test.sv
// self-checking bench for the buck fault and mode sequencer
`timescale 1ns/10ps
module buck_fault_mode_sequencer_test;
    // ****
    // stimulus, observation and model state
    // ****
    logic clk = 1'b0, sys_rst = 1'b1, cycle_start = 1'b0, pwm_demand = 1'b0;
    logic current_limit = 1'b0, reverse_current = 1'b0, conduction_mode_select = 1'b1;
    logic ext_ss_pull = 1'b0, tog_en = 1'b0, hs_q = 1'b0, ls_q = 1'b0, ls_mid, ls_late;
    logic hs_gate_low, ls_gate_low, restart_at_threshold, softstart_pin_low;
    logic hs, ls, rst_pull, rst_chg, ss_pull, clamp, comp_pull, standby, fcm;
    int bad_count = 0, comparisons = 0, cycles = 0;
    int hic = 0, clean = 0, miss = 0, hgl = 0, lgl = 0; // model counts
    integer seed = 32'he47b0694;
    bit p_dem = 1'b1, p_lim = 1'b0, x_fcm = 1'b1, x_hic = 1'b0; // model flags
    bfs_sequencer i_dut (
        .clk(clk), .sys_rst(sys_rst), .cycle_start(cycle_start), .pwm_demand(pwm_demand),
        .current_limit(current_limit), .reverse_current(reverse_current),
        .restart_at_threshold(restart_at_threshold), .softstart_pin_low(softstart_pin_low),
        .hs_gate_low(hs_gate_low), .ls_gate_low(ls_gate_low),
        .conduction_mode_select(conduction_mode_select), .high_side_gate_drive(hs),
        .low_side_gate_drive(ls), .restart_timer_pin_pull_low(rst_pull),
        .restart_charge_enable(rst_chg), .softstart_pull_low(ss_pull),
        .softstart_clamp_enable(clamp), .comp_pull_low(comp_pull), .standby(standby),
        .forced_continuous_mode(fcm)
    );
    bfs_power_stage #(.FALL(2), .RCHG(200), .SSCHG(40)) i_stage (
        .clk(clk), .high_side_gate_drive(hs), .low_side_gate_drive(ls),
        .restart_timer_pin_pull_low(rst_pull), .restart_charge_enable(rst_chg),
        .softstart_pull_low(ss_pull), .ext_ss_pull(ext_ss_pull), .hs_gate_low(hs_gate_low),
        .ls_gate_low(ls_gate_low), .restart_at_threshold(restart_at_threshold),
        .softstart_pin_low(softstart_pin_low)
    );
    // ****
    // helpers
    // ****
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (bad_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // one switching cycle; the model books the previous cycle at its start
    task automatic cyc(input bit dem, input bit lim, input bit rev);
        int n;
        n = 22 + ($random(seed) & 3);
        if (p_lim) begin
            hic++;
            clean = 0;
        end else begin
            clean++;
            if (clean >= 4) hic = 0;
        end
        if (hic == 512) begin
            x_hic = 1'b1;
            hic = 0;
        end
        miss = dem ? 0 : miss + (p_dem ? 0 : 1);
        p_dem = dem;
        p_lim = lim;
        @(posedge clk);
        #1;
        cycle_start = 1'b1;
        pwm_demand = dem;
        for (int i = 1; i < n; i++) begin
            @(posedge clk);
            #1;
            if (i == 1) cycle_start = 1'b0;
            pwm_demand = dem && i < 8;
            current_limit = lim && i >= 3 && i < 5;
            reverse_current = rev && i >= 19;
            if (i == 8) check(hs, dem && !lim && !x_hic);
            if (i == 18) ls_mid = ls;
        end
        ls_late = ls;
        check(standby, !x_fcm && miss >= 16);
        check(clamp, x_fcm || hic >= 32);
        check(ss_pull, x_hic);
        check(rst_pull, !x_hic);
        check(rst_chg, x_hic);
        check(fcm, x_fcm);
    endtask
    // clock and mode-pin clock
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (tog_en && cycles % 4 == 0) conduction_mode_select <= #1 ~conduction_mode_select;
    end
    // timeout and dead-time watch on every clock
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            bad_count++;
            end_of_test();
        end
        if (!sys_rst) begin
            check(hs & ls, 1'b0);
            if (ls && !ls_q) check(hgl >= 2, 1'b1);
            if (hs && !hs_q) check(lgl >= 2, 1'b1);
        end
        hgl = hs_gate_low ? hgl + 1 : 0;
        lgl = ls_gate_low ? lgl + 1 : 0;
        hs_q = hs;
        ls_q = ls;
    end
    // ****
    // main sequence
    // ****
    initial begin
        repeat (8) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        @(posedge clk);
        #1;
        check(rst_pull & clamp & fcm, 1'b1);
        check(hs | ls | standby | ss_pull, 1'b0);
        repeat (3) cyc(1, 0, 0);
        // outside pull on soft-start in continuous mode
        ext_ss_pull = 1'b1;
        repeat (2) cyc(0, 0, 0);
        check(ls, 1'b1);
        check(comp_pull, 1'b1);
        ext_ss_pull = 1'b0;
        repeat (3) cyc(1, 0, 0);
        // sustained overload into hiccup and restart
        repeat (512) cyc(1, 1, 0);
        cyc(1, 0, 0);
        check(hs | ls, 1'b0);
        check(comp_pull, 1'b1);
        for (int k = 0; k < 1000 && restart_at_threshold !== 1'b1; k++) @(posedge clk);
        repeat (4) @(posedge clk);
        #1;
        check(rst_pull, 1'b1);
        check(ss_pull, 1'b0);
        x_hic = 1'b0;
        for (int k = 0; k < 200 && softstart_pin_low !== 1'b0; k++) @(posedge clk);
        repeat (3) cyc(1, 0, 0);
        // four clean cycles clear the count
        repeat (300) cyc(1, 1, 0);
        repeat (4) cyc(1, 0, 0);
        repeat (300) cyc(1, 1, 0);
        repeat (4) cyc(1, 0, 0);
        // diode emulation
        conduction_mode_select = 1'b0;
        x_fcm = 1'b0;
        repeat (300) @(posedge clk);
        cyc(1, 0, 0);
        cyc(1, 0, 1);
        check(ls_mid, 1'b1);
        check(ls_late, 1'b0);
        repeat (33) cyc(1, 1, 0);
        repeat (5) cyc(1, 0, 0);
        repeat (17) cyc(0, 0, 0);
        cyc(1, 0, 0);
        // toggling mode pin selects continuous, no standby
        tog_en = 1'b1;
        repeat (300) @(posedge clk);
        x_fcm = 1'b1;
        repeat (20) cyc(0, 0, 0);
        end_of_test();
    end
endmodule
